/* File: rtl/pmce_pkg.sv */
// Shared constants and types for the power-up mode and configuration emulation block.
package pmce_pkg;

  // Start-up modes, fixed when the design is built.
  typedef enum logic [1:0] {
    PMCE_MODE_INSTANT = 2'h0,
    PMCE_MODE_DELAYED = 2'h1,
    PMCE_MODE_EMULATE = 2'h2
  } pmce_mode_type;

  // Sequencer states.
  typedef enum logic [1:0] {
    PMCE_ST_CLEAR = 2'h0,
    PMCE_ST_HOLD = 2'h1,
    PMCE_ST_EMUL = 2'h2,
    PMCE_ST_RUN = 2'h3
  } pmce_state_type;

  // Core clock rate in hertz (25 MHz).
  localparam int unsigned PMCE_CLK_HZ = 32'h017D_7840;
  // Nominal reset hold of the delayed mode, in milliseconds.
  localparam int unsigned PMCE_HOLD_TIME_MS = 50;
  // Hold length in core cycles, derived from the time and the clock rate.
  localparam int unsigned PMCE_HOLD_CYCLES = (PMCE_CLK_HZ / 1000) * PMCE_HOLD_TIME_MS;
  // Length of the internal power-on clear, in core cycles.
  localparam logic [7:0] PMCE_CLEAR_CYCLES = 8'h10;
  // Configuration clock edges that a full load would take.
  localparam int unsigned PMCE_LOAD_CLOCKS = 32'h0000_1000;
  // Embedded memory block geometry.
  localparam int unsigned PMCE_MEM_AW = 32'h8;
  localparam int unsigned PMCE_MEM_DW = 32'h8;
  // Seed that shapes the fixed ROM contents.
  localparam logic [7:0] PMCE_ROM_SEED = 8'hA5;
  // Reset value of every synchroniser stage.
  localparam logic PMCE_SYNC_RESET = 1'h0;

endpackage

/* File: rtl/pmce_sync.sv */
// Two-stage synchroniser for pins that arrive from outside the clock domain.
`timescale 1ns/10ps
module pmce_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Raw pin levels and their synchronised copies.
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  import pmce_pkg::*;

  // First stage; read only by the second stage to keep metastability contained.
  logic [WIDTH-1:0] meta_reg;

  // Both stages reset to a constant and then shift the pin level in.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= {WIDTH{PMCE_SYNC_RESET}};
      sync_o <= {WIDTH{PMCE_SYNC_RESET}};
    end else begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end

endmodule

/* File: rtl/pmce_mem.sv */
// Embedded memory block: a RAM with no preload and a ROM with fixed contents.
`timescale 1ns/10ps
module pmce_mem #(
  parameter int unsigned AW = pmce_pkg::PMCE_MEM_AW,
  parameter int unsigned DW = pmce_pkg::PMCE_MEM_DW
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // RAM port.
  input wire logic ram_we_i,
  input wire logic [AW-1:0] ram_addr_i,
  input wire logic [DW-1:0] ram_wdata_i,
  output logic [DW-1:0] ram_rdata_o,
  // ROM port.
  input wire logic [AW-1:0] rom_addr_i,
  output logic [DW-1:0] rom_rdata_o
);
  import pmce_pkg::*;

  // RAM array; deliberately neither reset nor initialised.
  logic [DW-1:0] ram_mem [0:(1<<AW)-1];

  // Fixed ROM contents, built from the address so no image file is needed.
  function automatic logic [DW-1:0] rom_word(input logic [AW-1:0] addr);
    logic [DW-1:0] word;
    word = DW'(addr) ^ DW'(PMCE_ROM_SEED);
    return word;
  endfunction

  // RAM write and registered read; contents start undefined after power-up.
  always_ff @(posedge clk_i) begin
    if (ram_we_i) begin
      ram_mem[ram_addr_i] <= ram_wdata_i;
    end
    ram_rdata_o <= ram_mem[ram_addr_i];
  end

  // ROM read register; valid from the first edge, the data need no load.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rom_rdata_o <= '0;
    end else begin
      rom_rdata_o <= rom_word(rom_addr_i);
    end
  end

  // ROM answers with its fixed word one cycle after the address.
  AST_ROM_CONTENTS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    1'b1 |=> rom_rdata_o == rom_word($past(rom_addr_i)))
    else $error("ROM read data do not match the fixed contents");

endmodule

/* File: rtl/pmce_top.sv */
// Power-up sequencer with instant, delayed and configuration-emulation start-up.
`timescale 1ns/10ps
module pmce_top #(
  parameter pmce_pkg::pmce_mode_type START_MODE = pmce_pkg::PMCE_MODE_INSTANT,
  parameter int unsigned HOLD_CYCLES = pmce_pkg::PMCE_HOLD_CYCLES,
  parameter int unsigned LOAD_CLOCKS = pmce_pkg::PMCE_LOAD_CLOCKS,
  parameter int unsigned AW = pmce_pkg::PMCE_MEM_AW,
  parameter int unsigned DW = pmce_pkg::PMCE_MEM_DW
) (
  // Clock and power-on reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Configuration pins driven by the host in emulation mode.
  input wire logic cfg_reload_n_i,
  input wire logic cfg_clk_i,
  input wire logic cfg_data_i,
  // Open-drain completion pin, split into level and enable.
  output logic config_complete_out_o,
  output logic config_complete_out_oe_o,
  // Reset and status for the user logic.
  output logic user_rst_n_o,
  output logic [1:0] seq_state_o,
  output logic cfg_parity_o,
  // Embedded memory block, RAM side.
  input wire logic ram_we_i,
  input wire logic [AW-1:0] ram_addr_i,
  input wire logic [DW-1:0] ram_wdata_i,
  output logic [DW-1:0] ram_rdata_o,
  // Embedded memory block, ROM side.
  input wire logic [AW-1:0] rom_addr_i,
  output logic [DW-1:0] rom_rdata_o
);
  import pmce_pkg::*;

  // Sequencer state and its next value.
  pmce_state_type state_reg;
  pmce_state_type state_next;
  // Power-on clear counter.
  logic [7:0] clear_cnt_reg;
  // Delayed-mode hold counter.
  logic [31:0] hold_cnt_reg;
  // Configuration clock edges seen in the current emulated load.
  logic [31:0] load_cnt_reg;
  // Synchronised configuration pins.
  logic [2:0] cfg_sync;
  logic cfg_reload_n;
  logic cfg_clk;
  logic cfg_data;
  // Previous synchronised clock level, for edge detection.
  logic cfg_clk_prev_reg;
  // Rising edge of the configuration clock while a load is allowed.
  logic cfg_edge;
  // Running parity of the emulated bitstream.
  logic cfg_parity_reg;
  // End markers of each phase.
  logic clear_done;
  logic hold_done;
  logic load_done;

  // The configuration pins are asynchronous, so they pass two flops first.
  pmce_sync #(
    .WIDTH(3)
  ) u_cfg_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i({cfg_reload_n_i, cfg_clk_i, cfg_data_i}),
    .sync_o(cfg_sync)
  );

  // Unpack the synchronised pins.
  assign cfg_reload_n = cfg_sync[2];
  assign cfg_clk = cfg_sync[1];
  assign cfg_data = cfg_sync[0];

  // A load clock counts only while the host is not holding reload low.
  assign cfg_edge = cfg_clk && !cfg_clk_prev_reg && cfg_reload_n;

  // Phase end conditions; the clear and hold counters stop at these values, the load counter one past its value.
  assign clear_done = clear_cnt_reg == PMCE_CLEAR_CYCLES - 8'h01;
  assign hold_done = hold_cnt_reg == 32'(HOLD_CYCLES - 1);
  assign load_done = cfg_edge && (load_cnt_reg == 32'(LOAD_CLOCKS - 1));

  // Next-state logic; the mode is a build parameter, so the path never changes.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      PMCE_ST_CLEAR: begin
        // Leave the clear in the way the build mode dictates.
        if (clear_done) begin
          unique case (START_MODE)
            PMCE_MODE_DELAYED: state_next = PMCE_ST_HOLD;
            PMCE_MODE_EMULATE: state_next = PMCE_ST_EMUL;
            default: state_next = PMCE_ST_RUN;
          endcase
        end
      end
      PMCE_ST_HOLD: begin
        // Extra reset hold, timed by the core clock alone.
        if (hold_done) begin
          state_next = PMCE_ST_RUN;
        end
      end
      PMCE_ST_EMUL: begin
        // Wait for the full number of load clocks from the host.
        if (load_done) begin
          state_next = PMCE_ST_RUN;
        end
      end
      PMCE_ST_RUN: begin
        // Stay operational until the next power-on reset.
        state_next = PMCE_ST_RUN;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= PMCE_ST_CLEAR;
    end else begin
      state_reg <= state_next;
    end
  end

  // Power-on clear timer, started by the release of the chip reset.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clear_cnt_reg <= 8'h00;
    end else if (state_reg == PMCE_ST_CLEAR && !clear_done) begin
      clear_cnt_reg <= clear_cnt_reg + 8'h01;
    end
  end

  // Hold timer; it needs no configuration pin to advance.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_cnt_reg <= 32'h0000_0000;
    end else if (state_reg == PMCE_ST_HOLD && !hold_done) begin
      hold_cnt_reg <= hold_cnt_reg + 32'h0000_0001;
    end
  end

  // Load clock counter; reload low from the host restarts the emulated load.
  // A host that stops mid-load leaves the count where it stood; only reload low
  // starts it again, so a cut load never completes by itself.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      load_cnt_reg <= 32'h0000_0000;
    end else if (state_reg == PMCE_ST_EMUL) begin
      if (!cfg_reload_n) begin
        load_cnt_reg <= 32'h0000_0000;
      end else if (cfg_edge) begin
        load_cnt_reg <= load_cnt_reg + 32'h0000_0001;
      end
    end
  end

  // Edge detector memory, fed from the second synchroniser stage.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_clk_prev_reg <= 1'h0;
    end else begin
      cfg_clk_prev_reg <= cfg_clk;
    end
  end

  // Bitstream parity, so the data pin is consumed as a real load would.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_parity_reg <= 1'h0;
    end else if (state_reg == PMCE_ST_EMUL) begin
      if (!cfg_reload_n) begin
        cfg_parity_reg <= 1'h0;
      end else if (cfg_edge) begin
        cfg_parity_reg <= cfg_parity_reg ^ cfg_data;
      end
    end
  end

  // Completion pin: pulled low until running, then released. Being open drain,
  // the level is always zero and only the enable moves.
  assign config_complete_out_o = 1'b0;
  assign config_complete_out_oe_o = state_reg != PMCE_ST_RUN;

  // User logic stays in reset through every start-up phase.
  assign user_rst_n_o = state_reg == PMCE_ST_RUN;

  // Status outputs straight from registers.
  assign seq_state_o = state_reg;
  assign cfg_parity_o = cfg_parity_reg;

  // Embedded memory; writes are blocked while the user logic is in reset.
  pmce_mem #(
    .AW(AW),
    .DW(DW)
  ) u_mem (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ram_we_i(ram_we_i && user_rst_n_o),
    .ram_addr_i(ram_addr_i),
    .ram_wdata_i(ram_wdata_i),
    .ram_rdata_o(ram_rdata_o),
    .rom_addr_i(rom_addr_i),
    .rom_rdata_o(rom_rdata_o)
  );

  // Helper: core cycles since reset release, saturating, read only by checks.
  logic [31:0] age_reg;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      age_reg <= 32'h0000_0000;
    end else if (age_reg != 32'hFFFF_FFFF) begin
      age_reg <= age_reg + 32'h0000_0001;
    end
  end

  // Number of cycles until the run state in the pin-free modes.
  localparam int unsigned CLEAR_LEN = int'(PMCE_CLEAR_CYCLES);
  localparam int unsigned DELAY_LEN = CLEAR_LEN + HOLD_CYCLES;

  // Named steps of the start-up.
  sequence clear_ending;
    state_reg == PMCE_ST_CLEAR && clear_done;
  endsequence

  sequence released_now;
    state_reg == PMCE_ST_RUN && !config_complete_out_oe_o && user_rst_n_o;
  endsequence

  sequence hold_entered;
    $rose(state_reg == PMCE_ST_HOLD);
  endsequence

  sequence reload_seen;
    state_reg == PMCE_ST_EMUL && !cfg_reload_n;
  endsequence

  AST_MODE_PATH: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_reg == PMCE_ST_HOLD |-> START_MODE == PMCE_MODE_DELAYED) and
    (state_reg == PMCE_ST_EMUL |-> START_MODE == PMCE_MODE_EMULATE))
    else $error("Start-up phase does not belong to the built mode");

  AST_CLEAR_HOLDS_USER: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    age_reg < 32'(CLEAR_LEN) |-> !user_rst_n_o && state_reg == PMCE_ST_CLEAR)
    else $error("User logic left reset before the clear ended");

  // The mode test is a plain sequence here, so it joins the clear step with a sequence and.
  AST_INSTANT_RELEASE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ((START_MODE == PMCE_MODE_INSTANT) and clear_ending) |=> released_now)
    else $error("Instant mode did not release completion after the clear");

  AST_INSTANT_NO_PINS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    START_MODE == PMCE_MODE_INSTANT && age_reg == 32'(CLEAR_LEN) |-> released_now)
    else $error("Instant mode not running at its fixed time");

  AST_HOLD_TIME: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_reg == PMCE_ST_HOLD && state_next == PMCE_ST_RUN
      |-> hold_cnt_reg == 32'(HOLD_CYCLES - 1) && age_reg == 32'(DELAY_LEN - 1))
    else $error("Reset hold ended at the wrong cycle");

  AST_HOLD_DRIVES_LOW: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    hold_entered |-> (config_complete_out_oe_o && !config_complete_out_o)[*2])
    else $error("Completion not driven low during the hold");

  AST_DELAYED_NO_PINS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    START_MODE == PMCE_MODE_DELAYED && age_reg == 32'(DELAY_LEN) |-> released_now)
    else $error("Delayed mode not running at its fixed time");

  AST_EMUL_COUNTS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_reg == PMCE_ST_EMUL && cfg_edge && !load_done
      |=> state_reg == PMCE_ST_EMUL && load_cnt_reg == $past(load_cnt_reg) + 32'h1)
    else $error("Emulated load missed a configuration clock");

  AST_EMUL_RELEASE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(config_complete_out_oe_o) && START_MODE == PMCE_MODE_EMULATE
      |-> $past(load_cnt_reg) == 32'(LOAD_CLOCKS - 1) && $past(cfg_edge))
    else $error("Completion released before the full load count");

  // A reload pulse from the host throws away the partial load, count and parity alike.
  AST_RELOAD_RESTARTS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    reload_seen |=> load_cnt_reg == 32'h0000_0000 && !cfg_parity_reg)
    else $error("Reload did not restart the emulated load");

  // Once running, only a new power-on reset brings the start-up back.
  AST_RUN_STAYS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_reg == PMCE_ST_RUN |=> state_reg == PMCE_ST_RUN && user_rst_n_o)
    else $error("Sequencer left the run state without a reset");

endmodule

/* File: verif/pmce_cfg_host.sv */
// Configuration host model that clocks emulated load data into the device.
`timescale 1ns/10ps
module pmce_cfg_host #(
  parameter int HALF_NS = 130,
  parameter logic [7:0] PATTERN = 8'h6D
) (
  // Configuration pins driven towards the device.
  output logic reload_n_o,
  output logic cfg_clk_o,
  output logic cfg_data_o
);
  // Index of the next bit of the pattern within the current load.
  int unsigned bit_idx;

  // Idle pins: clock stands low and reload is inactive outside a load.
  initial begin
    reload_n_o = 1'b1;
    cfg_clk_o = 1'b0;
    cfg_data_o = 1'b0;
    bit_idx = 0;
  end

  // Sends a number of clock periods; each half period spans more than three core cycles.
  task automatic send_clocks(input int count);
    for (int i = 0; i < count; i++) begin
      cfg_data_o = PATTERN[bit_idx % 8];
      #(HALF_NS);
      cfg_clk_o = 1'b1;
      #(HALF_NS);
      cfg_clk_o = 1'b0;
      // Past the hold time the line no longer shows the bit, so it is inverted.
      cfg_data_o = ~cfg_data_o;
      bit_idx++;
    end
  endtask

  // Pulls reload low long enough for the synchroniser, then restarts the pattern.
  task automatic restart();
    reload_n_o = 1'b0;
    #(4 * HALF_NS);
    reload_n_o = 1'b1;
    bit_idx = 0;
    #(2 * HALF_NS);
  endtask
endmodule

/* File: verif/tb_pmce_top.sv */
// Self-checking testbench running the three start-up modes side by side.
`timescale 1ns/10ps
module tb_pmce_top;
  import pmce_pkg::*;

  // Short counts keep the run brief; expectations derive from them.
  localparam int HOLD = 20;
  localparam int LOADS = 8;
  localparam int CLR = 16;
  localparam logic [7:0] PAT = 8'h6D;

  // Clock, reset and stimulus.
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] junk = 4'h0;
  logic ram_we = 1'b0;
  logic [7:0] ram_addr = 8'h00;
  logic [7:0] ram_wdata = 8'h00;
  logic [7:0] rom_addr = 8'h00;
  wire logic host_reload_n;
  wire logic host_clk;
  wire logic host_data;
  // Outputs of the three instances: 0 instant, 1 delayed, 2 emulated.
  logic [1:0] st [3];
  logic oe [3];
  logic out [3];
  logic urst [3];
  logic par [3];
  logic [7:0] ram_rd [3];
  logic [7:0] rom_rd [3];
  int err_total = 0;
  int n_checks = 0;

  // Core clock at 25 MHz.
  always #20 clk = ~clk;

  // Meaningless pin activity for the modes that must ignore their configuration pins.
  always @(posedge clk) begin
    #1 junk <= junk + 4'h1;
  end

  pmce_cfg_host #(.HALF_NS(130), .PATTERN(PAT)) i_host (
    .reload_n_o(host_reload_n),
    .cfg_clk_o(host_clk),
    .cfg_data_o(host_data)
  );

  pmce_top #(.START_MODE(PMCE_MODE_INSTANT), .HOLD_CYCLES(HOLD), .LOAD_CLOCKS(LOADS)) i_dut (
    .clk_i(clk), .rst_n_i(rst_n),
    .cfg_reload_n_i(junk[3]), .cfg_clk_i(junk[1]), .cfg_data_i(junk[0]),
    .config_complete_out_o(out[0]), .config_complete_out_oe_o(oe[0]),
    .user_rst_n_o(urst[0]), .seq_state_o(st[0]), .cfg_parity_o(par[0]),
    .ram_we_i(ram_we), .ram_addr_i(ram_addr), .ram_wdata_i(ram_wdata),
    .ram_rdata_o(ram_rd[0]), .rom_addr_i(rom_addr), .rom_rdata_o(rom_rd[0])
  );

  pmce_top #(.START_MODE(PMCE_MODE_DELAYED), .HOLD_CYCLES(HOLD), .LOAD_CLOCKS(LOADS)) i_dut_dly (
    .clk_i(clk), .rst_n_i(rst_n),
    .cfg_reload_n_i(junk[2]), .cfg_clk_i(junk[0]), .cfg_data_i(junk[1]),
    .config_complete_out_o(out[1]), .config_complete_out_oe_o(oe[1]),
    .user_rst_n_o(urst[1]), .seq_state_o(st[1]), .cfg_parity_o(par[1]),
    .ram_we_i(ram_we), .ram_addr_i(ram_addr), .ram_wdata_i(ram_wdata),
    .ram_rdata_o(ram_rd[1]), .rom_addr_i(rom_addr), .rom_rdata_o(rom_rd[1])
  );

  pmce_top #(.START_MODE(PMCE_MODE_EMULATE), .HOLD_CYCLES(HOLD), .LOAD_CLOCKS(LOADS)) i_dut_emu (
    .clk_i(clk), .rst_n_i(rst_n),
    .cfg_reload_n_i(host_reload_n), .cfg_clk_i(host_clk), .cfg_data_i(host_data),
    .config_complete_out_o(out[2]), .config_complete_out_oe_o(oe[2]),
    .user_rst_n_o(urst[2]), .seq_state_o(st[2]), .cfg_parity_o(par[2]),
    .ram_we_i(ram_we), .ram_addr_i(ram_addr), .ram_wdata_i(ram_wdata),
    .ram_rdata_o(ram_rd[2]), .rom_addr_i(rom_addr), .rom_rdata_o(rom_rd[2])
  );

  // Compares one value and counts it; a difference is reported at once.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // While reset is low every instance holds its user logic and pulls the pin low.
  task automatic t_reset_vals();
    for (int i = 0; i < 3; i++) begin
      chk(st[i], 32'h0);
      chk(oe[i], 32'h1);
      chk(urst[i], 32'h0);
      chk(par[i], 32'h0);
      chk(out[i], 32'h0);
    end
  endtask

  // Walks the edges after release; the ROM is read at every edge from the start.
  task automatic t_startup();
    for (int k = 1; k <= 40; k++) begin
      @(posedge clk);
      #1;
      chk(st[0], (k >= CLR) ? 32'h3 : 32'h0);
      chk(oe[0], (k >= CLR) ? 32'h0 : 32'h1);
      chk(urst[0], (k >= CLR) ? 32'h1 : 32'h0);
      chk(st[1], (k < CLR) ? 32'h0 : (k < CLR + HOLD) ? 32'h1 : 32'h3);
      chk(oe[1], (k < CLR + HOLD) ? 32'h1 : 32'h0);
      chk(urst[1], (k < CLR + HOLD) ? 32'h0 : 32'h1);
      chk(out[1], 32'h0);
      chk(par[0], 32'h0);
      chk(par[1], 32'h0);
      chk(st[2], (k < CLR) ? 32'h0 : 32'h2);
      chk(oe[2], 32'h1);
      chk(rom_rd[0], 32'(rom_addr ^ PMCE_ROM_SEED));
      rom_addr = k[7:0];
    end
  endtask

  // An aborted load, then one clock short of the full count, then completion.
  task automatic t_emulation();
    int waited;
    i_host.send_clocks(4);
    i_host.restart();
    i_host.send_clocks(LOADS - 1);
    repeat (6) @(posedge clk);
    #1;
    chk(st[2], 32'h2);
    chk(oe[2], 32'h1);
    i_host.send_clocks(1);
    waited = 0;
    while (st[2] !== 2'h3 && waited < 10) begin
      @(posedge clk);
      #1;
      waited++;
    end
    chk(st[2], 32'h3);
    chk(oe[2], 32'h0);
    chk(urst[2], 32'h1);
    chk(par[2], {31'h0, ^PAT});
  endtask

  // Two writes to one address show the read-before-write value, then the new one.
  task automatic t_ram();
    @(posedge clk);
    #1;
    ram_we = 1'b1;
    ram_addr = 8'h05;
    ram_wdata = 8'h3C;
    @(posedge clk);
    #1;
    ram_wdata = 8'hC3;
    @(posedge clk);
    #1;
    chk(ram_rd[0], 32'h3C);
    ram_we = 1'b0;
    @(posedge clk);
    #1;
    chk(ram_rd[0], 32'hC3);
  endtask

  // Main sequence: power-up, the three modes, memory, and a reset in mid-run.
  initial begin
    repeat (2) @(posedge clk);
    #1;
    t_reset_vals();
    rst_n = 1'b1;
    t_startup();
    t_emulation();
    t_ram();
    @(posedge clk);
    #1;
    rst_n = 1'b0;
    #1;
    t_reset_vals();
    // Hold the second reset over two edges, then watch the whole start-up again.
    repeat (2) @(posedge clk);
    #1;
    t_reset_vals();
    rst_n = 1'b1;
    t_startup();
    conclude();
  end

  // Watchdog: the whole sequence needs well under 200 us.
  initial begin
    #200000;
    err_total++;
    conclude();
  end
endmodule
